// [common/ctd_pkg.sv]
// Purpose: types for the instruction timing decoder
// Assumes: one instruction in flight at a time
// Notes: state travels as one packed struct
package ctd_pkg;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EXEC = 2'h1} ctd_state_e;
   typedef enum logic [2:0] {SP_NONE = 3'h0, SP_IRAM = 3'h1, SP_SPECIAL = 3'h2, SP_IDIR = 3'h3,
      SP_CODE = 3'h4, SP_XDATA = 3'h5} ctd_space_e;
   typedef enum logic [2:0] {TK_NONE = 3'h0, TK_REL1 = 3'h1, TK_REL2 = 3'h2, TK_ABS = 3'h3,
      TK_LONG = 3'h4, TK_RUN = 3'h5} ctd_tgt_e;
   typedef enum logic [2:0] {OK_NONE = 3'h0, OK_REG = 3'h1, OK_IND = 3'h2, OK_DIR = 3'h3,
      OK_IND_DIR = 3'h4, OK_CODE = 3'h5, OK_XRI = 3'h6, OK_XPTR = 3'h7} ctd_opnd_e;
   typedef struct packed {
      logic [1:0] len;
      logic [2:0] cyc;
      logic cond;
      ctd_tgt_e tk;
      ctd_opnd_e opk;
      logic nib;
      logic tclr;
   } ctd_dec_s;
   typedef struct packed {
      ctd_state_e state;
      logic busy;
      logic done;
      logic [2:0] rem;
      logic [1:0] len;
      logic [2:0] cyc;
      logic taken;
      logic jump;
      logic [15:0] target;
      logic [7:0] reg_addr;
      logic [7:0] data_addr;
      ctd_space_e space;
      logic nibble;
      logic clear;
   } ctd_st_s;
endpackage : ctd_pkg

// [common/ctd_regs.svh]
// Purpose: opcode patterns, lengths and cycle counts for the timing decoder
// Assumes: patterns are matched with casez; list macros expand to case labels
// Notes: bank select sits in the status word; bit 7 of a direct address picks special registers
// Behaviour
// - Indirect store: from A 1 byte/2 cycles, direct or immediate 2/2; immediate-to-direct 3/3
// - Loading the pointer pair with a 16-bit constant takes 3 bytes, 3 cycles
// - Both code-byte reads use A plus pointer or PC; 1 byte, 3 cycles
// - All six external-data moves take 1 byte, 3 cycles; 8-bit or 16-bit address
// - Stack push and pop of a direct byte take 2 bytes, 2 cycles
// - Exchange with A: register 1/1, direct 2/2, indirect 1/2
// - Nibble exchange swaps only low four bits, 1 byte, 2 cycles
// - Carry clear/set/complement 1/1; every direct-bit operation 2/2
// - Carry and accumulator conditional jumps: 2 bytes, 2 or 3 cycles
// - Bit conditional jumps 3 bytes, 3 or 4 cycles; test-and-clear clears set bit
// - Absolute call 2 bytes/3 cycles; long call 3 bytes/4 cycles
// - Both returns are 1 byte and take 5 cycles
// - Absolute and short jumps 2/3, long jump 3/4, indirect jump 1/3
// - Compare-jump 3 bytes; 3 or 4 cycles, indirect form 4 or 5
// - Decrement-jump: register 2 bytes 2/3 cycles, direct 3 bytes 3/4 cycles
// - No-operation and the spare opcode both take 1 byte, 1 cycle
// - Register operand picks one of eight registers in current bank
// - Indirect operand addresses RAM through register 0 or 1 of current bank
// - Relative offset is signed 8-bit, added to next instruction address
// - Direct address below 0x80 is RAM, from 0x80 up is special register space
// - Absolute target is 11 bits within the 2K page of next instruction
// - Program and data spaces are separate; instruction type selects the space
// - An untaken conditional branch ends one cycle before the taken one
// - Durations count system clocks only, no grouped machine cycles
// - Status word bits 3 and 4 select the active register bank
`ifndef CTD_REGS_SVH
`define CTD_REGS_SVH
`define CTD_L1 2'h1
`define CTD_L2 2'h2
`define CTD_L3 2'h3
`define CTD_C1 3'h1
`define CTD_CYC2 3'h2
`define CTD_C3 3'h3
`define CTD_C4 3'h4
`define CTD_C5 3'h5
`define CTD_BANK_HI 4
`define CTD_BANK_LO 3
`define CTD_SPECIAL_BIT 7
`define CTD_PAGE_LSB 11
`define CTD_OP_NOP 8'h00
`define CTD_OP_SPARE 8'hA5
`define CTD_OP_ST_IND_A 8'b1111_011?
`define CTD_OP_ST_IND_DIR 8'b1010_011?
`define CTD_OP_ST_IND_IMM 8'b0111_011?
`define CTD_OP_ST_DIR_IMM 8'h75
`define CTD_OP_LOAD_PTR 8'h90
`define CTD_OP_CODE_RD 8'b100?_0011
`define CTD_OP_XDATA_IX 8'b111?_001?
`define CTD_OP_XDATA_PTR 8'b111?_0000
`define CTD_OP_STACK 8'b110?_0000
`define CTD_OP_XCH_REG 8'b1100_1???
`define CTD_OP_XCH_DIR 8'hC5
`define CTD_OP_XCH_IND 8'b1100_011?
`define CTD_OP_NIBBLE 8'b1101_011?
`define CTD_OP_CARRY 8'hC3, 8'hD3, 8'hB3
`define CTD_OP_BITS 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92
`define CTD_OP_JFLAG 8'b01??_0000
`define CTD_OP_JBIT 8'b001?_0000
`define CTD_OP_JCLR 8'h10
`define CTD_OP_ABS_CALL 8'b???1_0001
`define CTD_OP_LONG_CALL 8'h12
`define CTD_OP_RETS 8'b001?_0010
`define CTD_OP_ABS_JUMP 8'b???0_0001
`define CTD_OP_LONG_JUMP 8'h02
`define CTD_OP_SHORT_JUMP 8'h80
`define CTD_OP_JMP_IND 8'h73
`define CTD_OP_CMPJ_DIR 8'hB5
`define CTD_OP_CMPJ_IMM 8'hB4
`define CTD_OP_CMPJ_REG 8'b1011_1???
`define CTD_OP_CMPJ_IND 8'b1011_011?
`define CTD_OP_DECJ_REG 8'b1101_1???
`define CTD_OP_DECJ_DIR 8'hD5
`endif

// [rtl/ctd_decode.sv]
// Purpose: byte length, clock count and operand decode for one instruction
// Assumes: opcode, operands, status word and pointer value are valid with I_VALID
// Notes: O_DONE marks the last clock of the instruction in flight
`timescale 1ns/1ps
`default_nettype none
`include "ctd_regs.svh"

module ctd_decode (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire logic I_VALID,
   input wire logic [7:0] I_OPCODE,
   input wire logic [7:0] I_OPND1,
   input wire logic [7:0] I_OPND2,
   input wire logic [15:0] I_NEXT_PC,
   input wire logic [7:0] I_PROGRAM_STATUS_WORD,
   input wire logic [7:0] I_PTR,
   input wire logic I_COND,
   output logic O_BUSY,
   output logic O_DONE,
   output logic [1:0] O_LEN,
   output logic [2:0] O_CYCLES,
   output logic O_TAKEN,
   output logic O_JUMP,
   output logic [15:0] O_TARGET,
   output logic [7:0] O_REG_ADDR,
   output logic [7:0] O_DATA_ADDR,
   output logic [2:0] O_SPACE,
   output logic O_NIBBLE,
   output logic O_CLEAR_BIT
);

   function automatic ctd_pkg::ctd_dec_s decode(input logic [7:0] op);
      ctd_pkg::ctd_dec_s d;
      d.len = `CTD_L1;
      d.cyc = `CTD_C1;
      d.cond = 1'b0;
      d.tk = ctd_pkg::TK_NONE;
      d.opk = ctd_pkg::OK_NONE;
      d.nib = 1'b0;
      d.tclr = 1'b0;
      casez (op)
         `CTD_OP_NOP, `CTD_OP_SPARE: d.cyc = `CTD_C1;
         `CTD_OP_ST_IND_A: begin
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_IND;
         end
         `CTD_OP_ST_IND_DIR: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_IND_DIR;
         end
         `CTD_OP_ST_IND_IMM: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_IND;
         end
         `CTD_OP_ST_DIR_IMM: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C3;
            d.opk = ctd_pkg::OK_DIR;
         end
         `CTD_OP_LOAD_PTR: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C3;
         end
         `CTD_OP_CODE_RD: begin
            d.cyc = `CTD_C3;
            d.opk = ctd_pkg::OK_CODE;
         end
         `CTD_OP_XDATA_IX: begin
            d.cyc = `CTD_C3;
            d.opk = ctd_pkg::OK_XRI;
         end
         `CTD_OP_XDATA_PTR: begin
            d.cyc = `CTD_C3;
            d.opk = ctd_pkg::OK_XPTR;
         end
         `CTD_OP_STACK: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_DIR;
         end
         `CTD_OP_XCH_REG: d.opk = ctd_pkg::OK_REG;
         `CTD_OP_XCH_DIR: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_DIR;
         end
         `CTD_OP_XCH_IND: begin
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_IND;
         end
         `CTD_OP_NIBBLE: begin
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_IND;
            d.nib = 1'b1;
         end
         `CTD_OP_CARRY: d.cyc = `CTD_C1;
         `CTD_OP_BITS: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_CYC2;
            d.opk = ctd_pkg::OK_DIR;
         end
         `CTD_OP_JFLAG: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_C3;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL1;
         end
         `CTD_OP_JCLR, `CTD_OP_JBIT: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C4;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL2;
            d.opk = ctd_pkg::OK_DIR;
            d.tclr = (op == `CTD_OP_JCLR);
         end
         `CTD_OP_ABS_CALL: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_C3;
            d.tk = ctd_pkg::TK_ABS;
         end
         `CTD_OP_LONG_CALL: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C4;
            d.tk = ctd_pkg::TK_LONG;
         end
         `CTD_OP_RETS: begin
            d.cyc = `CTD_C5;
            d.tk = ctd_pkg::TK_RUN;
         end
         `CTD_OP_ABS_JUMP: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_C3;
            d.tk = ctd_pkg::TK_ABS;
         end
         `CTD_OP_LONG_JUMP: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C4;
            d.tk = ctd_pkg::TK_LONG;
         end
         `CTD_OP_SHORT_JUMP: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_C3;
            d.tk = ctd_pkg::TK_REL1;
         end
         `CTD_OP_JMP_IND: begin
            d.cyc = `CTD_C3;
            d.tk = ctd_pkg::TK_RUN;
         end
         `CTD_OP_CMPJ_DIR, `CTD_OP_CMPJ_IMM: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C4;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL2;
            d.opk = (op == `CTD_OP_CMPJ_DIR) ? ctd_pkg::OK_DIR : ctd_pkg::OK_NONE;
         end
         `CTD_OP_CMPJ_REG: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C4;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL2;
            d.opk = ctd_pkg::OK_REG;
         end
         `CTD_OP_CMPJ_IND: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C5;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL2;
            d.opk = ctd_pkg::OK_IND;
         end
         `CTD_OP_DECJ_REG: begin
            d.len = `CTD_L2;
            d.cyc = `CTD_C3;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL1;
            d.opk = ctd_pkg::OK_REG;
         end
         `CTD_OP_DECJ_DIR: begin
            d.len = `CTD_L3;
            d.cyc = `CTD_C4;
            d.cond = 1'b1;
            d.tk = ctd_pkg::TK_REL2;
            d.opk = ctd_pkg::OK_DIR;
         end
         default: d.cyc = `CTD_C1;
      endcase
      return d;
   endfunction : decode

   ctd_pkg::ctd_st_s st_r;
   ctd_pkg::ctd_st_s st_nxt;
   ctd_pkg::ctd_dec_s dec;
   logic acc;
   logic go;
   logic [1:0] bank;
   logic [2:0] cyc_eff;
   logic [15:0] tgt;
   logic [7:0] ra;
   logic [7:0] da;
   ctd_pkg::ctd_space_e sp;

   assign acc = I_VALID && (st_r.state == ctd_pkg::ST_IDLE);

   always_comb begin
      dec = decode(I_OPCODE);
      bank = I_PROGRAM_STATUS_WORD[`CTD_BANK_HI:`CTD_BANK_LO];
      go = (dec.tk != ctd_pkg::TK_NONE) && (!dec.cond || I_COND);
      cyc_eff = (dec.cond && !I_COND) ? dec.cyc - 3'h1 : dec.cyc;
      case (dec.tk)
         ctd_pkg::TK_REL1: tgt = I_NEXT_PC + {{8{I_OPND1[7]}}, I_OPND1};
         ctd_pkg::TK_REL2: tgt = I_NEXT_PC + {{8{I_OPND2[7]}}, I_OPND2};
         ctd_pkg::TK_ABS: tgt = {I_NEXT_PC[15:`CTD_PAGE_LSB], I_OPCODE[7:5], I_OPND1};
         ctd_pkg::TK_LONG: tgt = {I_OPND1, I_OPND2};
         default: tgt = 16'h0000;
      endcase
      ra = 8'h00;
      da = 8'h00;
      sp = ctd_pkg::SP_NONE;
      case (dec.opk)
         ctd_pkg::OK_REG: begin
            ra = {3'h0, bank, I_OPCODE[2:0]};
         end
         ctd_pkg::OK_IND, ctd_pkg::OK_IND_DIR: begin
            ra = {3'h0, bank, 2'h0, I_OPCODE[0]};
            da = I_PTR;
            sp = ctd_pkg::SP_IDIR;
         end
         ctd_pkg::OK_XRI: begin
            ra = {3'h0, bank, 2'h0, I_OPCODE[0]};
            da = I_PTR;
            sp = ctd_pkg::SP_XDATA;
         end
         ctd_pkg::OK_XPTR: sp = ctd_pkg::SP_XDATA;
         ctd_pkg::OK_CODE: sp = ctd_pkg::SP_CODE;
         ctd_pkg::OK_DIR: begin
            da = I_OPND1;
            if (I_OPND1[`CTD_SPECIAL_BIT]) begin
               sp = ctd_pkg::SP_SPECIAL;
            end else begin
               sp = ctd_pkg::SP_IRAM;
            end
         end
         default: sp = ctd_pkg::SP_NONE;
      endcase
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      case (st_r.state)
         ctd_pkg::ST_IDLE: begin
            if (I_VALID) begin
               st_nxt.len = dec.len;
               st_nxt.cyc = cyc_eff;
               st_nxt.taken = go;
               st_nxt.jump = go && (dec.tk != ctd_pkg::TK_RUN);
               st_nxt.target = tgt;
               st_nxt.reg_addr = ra;
               st_nxt.data_addr = da;
               st_nxt.space = sp;
               st_nxt.nibble = dec.nib;
               st_nxt.clear = dec.tclr && I_COND;
               st_nxt.rem = cyc_eff - 3'h1;
               if (cyc_eff == `CTD_C1) begin
                  st_nxt.done = 1'b1;
               end else begin
                  st_nxt.state = ctd_pkg::ST_EXEC;
                  st_nxt.busy = 1'b1;
               end
            end
         end
         ctd_pkg::ST_EXEC: begin
            // One count per system clock
            if (st_r.rem == 3'h1) begin
               st_nxt.done = 1'b1;
               st_nxt.busy = 1'b0;
               st_nxt.state = ctd_pkg::ST_IDLE;
            end
            st_nxt.rem = st_r.rem - 3'h1;
         end
         default: begin
            st_nxt.state = ctd_pkg::ST_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign O_BUSY = st_r.busy;
   assign O_DONE = st_r.done;
   assign O_LEN = st_r.len;
   assign O_CYCLES = st_r.cyc;
   assign O_TAKEN = st_r.taken;
   assign O_JUMP = st_r.jump;
   assign O_TARGET = st_r.target;
   assign O_REG_ADDR = st_r.reg_addr;
   assign O_DATA_ADDR = st_r.data_addr;
   assign O_SPACE = st_r.space;
   assign O_NIBBLE = st_r.nibble;
   assign O_CLEAR_BIT = st_r.clear;

   ret_five_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_RETS) |-> ##1 (!st_r.done)[*4] ##1 st_r.done)
      else $error("return did not finish in five clocks");

   spare_nop_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE == `CTD_OP_SPARE) |=> st_r.done && (st_r.len == `CTD_L1)
         && (st_r.cyc == `CTD_C1) && !st_r.taken)
      else $error("spare opcode not decoded as no-operation");

   untaken_short_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_JFLAG) && !I_COND |-> ##1 (st_r.cyc == `CTD_CYC2)
         && !st_r.taken ##1 st_r.done)
      else $error("untaken flag jump not two clocks");

   bit_clear_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE == `CTD_OP_JCLR) && I_COND |=> st_r.clear && st_r.taken
         && (st_r.cyc == `CTD_C4) && (st_r.len == `CTD_L3))
      else $error("test-and-clear jump wrong");

   rel_target_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE == `CTD_OP_SHORT_JUMP) |=> st_r.jump
         && (st_r.target == $past(I_NEXT_PC) + {{8{$past(I_OPND1[7])}}, $past(I_OPND1)}))
      else $error("short jump target wrong");

   page_keep_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_ABS_JUMP) |=> st_r.jump
         && (st_r.target[15:11] == $past(I_NEXT_PC[15:11]))
         && (st_r.target[7:0] == $past(I_OPND1)))
      else $error("absolute jump left its page");

   bank_reg_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_XCH_REG) |=> (st_r.cyc == `CTD_C1)
         && (st_r.reg_addr == {3'h0, $past(I_PROGRAM_STATUS_WORD[4:3]), $past(I_OPCODE[2:0])}))
      else $error("bank register address wrong");

   sfr_space_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_STACK) |=> (st_r.space == ($past(I_OPND1[7])
         ? ctd_pkg::SP_SPECIAL : ctd_pkg::SP_IRAM)) && (st_r.cyc == `CTD_CYC2))
      else $error("direct operand space wrong");

   ind_ptr_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_ST_IND_A) |=> (st_r.space == ctd_pkg::SP_IDIR)
         && (st_r.data_addr == $past(I_PTR)))
      else $error("indirect store address wrong");

   code_read_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_CODE_RD) |-> ##1 (st_r.space == ctd_pkg::SP_CODE)
         && !st_r.done ##1 !st_r.done ##1 st_r.done)
      else $error("code read not three clocks");

   cmp_ind_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      acc && (I_OPCODE ==? `CTD_OP_CMPJ_IND) |=> (st_r.cyc == ($past(I_COND)
         ? `CTD_C5 : `CTD_C4)) && (st_r.len == `CTD_L3))
      else $error("indirect compare-jump timing wrong");

endmodule : ctd_decode
`default_nettype wire

// [verif/ctd_iram_model.sv]
// Purpose: internal data RAM behind the decoder's indirect and register forms
// Assumes: read is combinational, address formed by the bench
// Notes: each byte holds the inverse of its own address
`timescale 1ns/1ps
`default_nettype none

module ctd_iram_model (
   input wire logic [7:0] i_addr,
   output logic [7:0] o_data
);
   logic [7:0] mem_r [0:255];

   initial begin : fill
      for (int i = 0; i < 256; i++) begin
         mem_r[i] = ~8'(i);
      end
   end

   // Bank registers occupy the lowest 32 bytes
   assign o_data = mem_r[i_addr];
endmodule : ctd_iram_model

`default_nettype wire

// [verif/tb_top.sv]
// Purpose: self-checking bench for the instruction timing decoder
// Assumes: one instruction offered at a time with all its operand bytes
// Notes: expected timing is kept in a table of its own here
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int NOPS = 65;
   localparam logic [7:0] OPS [NOPS] = '{8'hF6, 8'hF7, 8'hA6, 8'hA7, 8'h76, 8'h77, 8'h75,
      8'h90, 8'h93, 8'h83, 8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'hE0, 8'hF0, 8'hC0, 8'hD0, 8'hC8,
      8'hCF, 8'hC5, 8'hC6, 8'hC7, 8'hD6, 8'hD7, 8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2,
      8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30,
      8'h10, 8'h11, 8'hF1, 8'h12, 8'h22, 8'h32, 8'h01, 8'hE1, 8'h02, 8'h80, 8'h73, 8'hB5,
      8'hB4, 8'hB8, 8'hBF, 8'hB6, 8'hB7, 8'hD8, 8'hDF, 8'hD5, 8'h00, 8'hA5};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic vld = 1'b0;
   logic cond = 1'b0;
   logic [7:0] opc = 8'h00;
   logic [7:0] op1 = 8'h00;
   logic [7:0] op2 = 8'h00;
   logic [7:0] stat_word = 8'h00;
   logic [15:0] npc = 16'h0100;
   wire logic [7:0] ptr;
   wire logic [7:0] ptr_loc;
   logic busy, done, taken, jump, nib, clr;
   logic [1:0] len;
   logic [2:0] cyc, space;
   logic [15:0] tgt;
   logic [7:0] raddr, daddr;
   int n_errors = 0;
   int checked = 0;

   // Pointer register R0 or R1 of the active bank
   assign ptr_loc = {3'h0, stat_word[4:3], 2'h0, opc[0]};

   ctd_decode u_ctd_decode (.I_CLOCK(clock), .I_SYS_RST(rst), .I_VALID(vld), .I_OPCODE(opc),
      .I_OPND1(op1), .I_OPND2(op2), .I_NEXT_PC(npc), .I_PROGRAM_STATUS_WORD(stat_word),
      .I_PTR(ptr), .I_COND(cond),
      .O_BUSY(busy), .O_DONE(done), .O_LEN(len), .O_CYCLES(cyc), .O_TAKEN(taken),
      .O_JUMP(jump), .O_TARGET(tgt), .O_REG_ADDR(raddr), .O_DATA_ADDR(daddr),
      .O_SPACE(space), .O_NIBBLE(nib), .O_CLEAR_BIT(clr));
   ctd_iram_model u_ctd_iram_model (.i_addr(ptr_loc), .o_data(ptr));

   always #50 clock = ~clock;

   // Returns length, cycles when taken, conditional, flow change
   function automatic logic [6:0] ref_lc(input logic [7:0] op);
      casez (op)
         8'hF6, 8'hF7, 8'hC6, 8'hC7, 8'hD6, 8'hD7: return {2'h1, 3'h2, 2'h0};
         8'hA6, 8'hA7, 8'h76, 8'h77, 8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0,
            8'h72, 8'hA0, 8'hA2, 8'h92: return {2'h2, 3'h2, 2'h0};
         8'h75, 8'h90: return {2'h3, 3'h3, 2'h0};
         8'h93, 8'h83, 8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'hE0, 8'hF0: return {2'h1, 3'h3, 2'h0};
         8'h73: return {2'h1, 3'h3, 2'h1};
         8'h22, 8'h32: return {2'h1, 3'h5, 2'h1};
         8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: return {2'h2, 3'h3, 2'h3};
         8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'b1011_1???, 8'hD5: return {2'h3, 3'h4, 2'h3};
         8'hB6, 8'hB7: return {2'h3, 3'h5, 2'h3};
         8'b????_0001, 8'h80: return {2'h2, 3'h3, 2'h1};
         8'h02, 8'h12: return {2'h3, 3'h4, 2'h1};
         default: return {2'h1, 3'h1, 2'h0};
      endcase
   endfunction : ref_lc

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // Offer one instruction, follow it to its last clock
   task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
      input logic c);
      logic [6:0] r;
      logic [2:0] n;
      logic [2:0] e;
      r = ref_lc(op);
      e = r[4:2] - {2'h0, r[1] & ~c};
      opc = op;
      op1 = a;
      op2 = b;
      cond = c;
      vld = 1'b1;
      @(posedge clock);
      #1;
      vld = 1'b0;
      n = 3'h1;
      while (done !== 1'b1 && n < 3'h7) begin
         chk(16'(busy), 16'h1);
         @(posedge clock);
         #1;
         n = n + 3'h1;
      end
      chk(16'(n), 16'(e));
      chk(16'(cyc), 16'(e));
      chk(16'(len), 16'(r[6:5]));
      chk(16'(busy), 16'h0);
      chk(16'(taken), 16'(r[0] & (c | ~r[1])));
      // Idle clock so valid never toggles twice in one step
      @(posedge clock);
      #1;
   endtask : run

   task automatic t_reset;
      chk(16'(len), 16'h0);
      chk(16'(busy), 16'h0);
      chk(16'(space), 16'h0);
      chk(tgt, 16'h0000);
   endtask : t_reset

   task automatic t_timing;
      for (int i = 0; i < NOPS; i++) begin
         run(OPS[i], 8'h45, 8'h10, 1'b0);
         run(OPS[i], 8'h45, 8'h10, 1'b1);
      end
   endtask : t_timing

   task automatic t_operands;
      for (int b = 0; b < 4; b++) begin
         stat_word = {3'h0, 2'(b), 3'h0};
         run(8'hCD, 8'h00, 8'h00, 1'b0);
         chk(16'(raddr), 16'({2'(b), 3'h5}));
         run(8'hC7, 8'h00, 8'h00, 1'b0);
         chk(16'(raddr), 16'({2'(b), 3'h1}));
         chk(16'(daddr), 16'(8'(~{3'h0, 2'(b), 3'h1})));
         chk(16'(space), 16'h3);
      end
      run(8'hC5, 8'h7F, 8'h00, 1'b0);
      chk(16'(space), 16'h1);
      chk(16'(daddr), 16'h7F);
      run(8'hC5, 8'h80, 8'h00, 1'b0);
      chk(16'(space), 16'h2);
      run(8'hE3, 8'h00, 8'h00, 1'b0);
      chk(16'(space), 16'h5);
      chk(16'(daddr), 16'hE6);
      run(8'hE0, 8'h00, 8'h00, 1'b0);
      chk(16'(daddr), 16'h00);
      run(8'h93, 8'h00, 8'h00, 1'b0);
      chk(16'(space), 16'h4);
      run(8'hD6, 8'h00, 8'h00, 1'b0);
      chk(16'(nib), 16'h1);
      chk(16'(daddr), 16'hE7);
      run(8'hC6, 8'h00, 8'h00, 1'b0);
      chk(16'(nib), 16'h0);
      run(8'h10, 8'h20, 8'h05, 1'b1);
      chk(16'(clr), 16'h1);
      run(8'h10, 8'h20, 8'h05, 1'b0);
      chk(16'(clr), 16'h0);
   endtask : t_operands

   task automatic t_targets;
      stat_word = 8'h00;
      npc = 16'h0100;
      run(8'h80, 8'hFE, 8'h00, 1'b0);
      chk(16'(jump), 16'h1);
      chk(tgt, 16'h00FE);
      run(8'h30, 8'h20, 8'h7F, 1'b1);
      chk(tgt, 16'h017F);
      run(8'h30, 8'h20, 8'h7F, 1'b0);
      chk(16'(jump), 16'h0);
      npc = 16'h2800;
      run(8'hE1, 8'h22, 8'h00, 1'b0);
      chk(tgt, 16'h2F22);
      run(8'hF1, 8'h22, 8'h00, 1'b0);
      chk(tgt, 16'h2F22);
      run(8'h02, 8'h12, 8'h34, 1'b0);
      chk(tgt, 16'h1234);
      run(8'h22, 8'h00, 8'h00, 1'b0);
      chk(16'(jump), 16'h0);
   endtask : t_targets

   // A second offer during a return must be ignored
   task automatic t_refuse;
      int n;
      opc = 8'h22;
      vld = 1'b1;
      @(posedge clock);
      #1;
      opc = 8'h00;
      @(posedge clock);
      #1;
      vld = 1'b0;
      n = 2;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(16'(n), 16'h5);
      chk(16'(cyc), 16'h5);
      chk(16'(len), 16'h1);
   endtask : t_refuse

   initial begin : main
      repeat (2) @(posedge clock);
      #1;
      rst = 1'b0;
      t_reset;
      t_timing;
      t_operands;
      t_targets;
      t_refuse;
      report_and_stop;
   end

   initial begin : watchdog
      #(100 * 5000);
      n_errors++;
      report_and_stop;
   end
endmodule : tb_top

`default_nettype wire
